// *** core/spimp_master.sv ***
`timescale 1ns/1ps
module spimp_master
  import spimp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        start,
  input  wire logic [15:0] tx_data,
  input  wire logic [3:0]  word_len,
  input  wire logic        cpol,
  input  wire logic        cpha,
  input  wire logic        three_wire,
  input  wire logic        read_dir,
  input  wire logic [7:0]  half_div,
  output logic             busy,
  output logic             done,
  output logic [15:0]      rx_data,
  input  wire logic [3:0]  gpio_mode,
  input  wire logic [3:0]  gpio_in_en,
  input  wire logic [3:0]  gpio_out,
  output logic [3:0]       gpio_in,
  input  wire logic [3:0]  pin_i,
  output logic [3:0]       pin_o,
  output logic [3:0]       pin_oe
);

  spimp_reg_t r;
  spimp_reg_t next_r;
  logic [7:0] half_c;
  logic [15:0] load_sh;
  logic [3:0] spi_o;
  logic [3:0] spi_oe;

  always_comb begin
    if (half_div < 8'(HALF_MIN_CYC)) begin
      half_c = 8'(HALF_MIN_CYC);
    end else if (half_div > 8'(HALF_MAX_CYC)) begin
      half_c = 8'(HALF_MAX_CYC);
    end else begin
      half_c = half_div;
    end
    load_sh = tx_data << (4'hF - word_len);
  end

  always_comb begin
    next_r = r;
    next_r.s1 = pin_i;
    next_r.s2 = r.s1;
    next_r.done = 1'b0;
    next_r.samp = {r.samp[0], 1'b0};
    if (r.samp[1]) begin
      next_r.rx = {r.rx[14:0], r.tw ? r.s2[PIN_DO] : r.s2[PIN_DI]};
    end
    case (r.st)
      SPIMP_IDLE: begin
        next_r.cs_n = CS_IDLE;
        next_r.sclk = cpol;
        if (start) begin
          next_r.cpol = cpol;
          next_r.cpha = cpha;
          next_r.tw   = three_wire;
          next_r.rd   = read_dir;
          next_r.len  = word_len;
          next_r.half = half_c;
          next_r.cnt  = half_c - 8'h01;
          next_r.edg  = 5'h00;
          next_r.rx   = 16'h0000;
          next_r.dout = load_sh[15];
          next_r.sh   = cpha ? load_sh : {load_sh[14:0], 1'b0};
          next_r.cs_n = 1'b0;
          next_r.st   = SPIMP_LEAD;
        end
      end
      SPIMP_LEAD: begin
        if (r.cnt == 8'h00) begin
          next_r.cnt = r.half - 8'h01;
          next_r.st  = SPIMP_XFER;
        end else begin
          next_r.cnt = r.cnt - 8'h01;
        end
      end
      SPIMP_XFER: begin
        if (r.cnt != 8'h00) begin
          next_r.cnt = r.cnt - 8'h01;
        end else begin
          next_r.cnt  = r.half - 8'h01;
          next_r.sclk = ~r.sclk;
          if (~r.edg[0] ^ r.cpha) begin
            next_r.samp[0] = 1'b1;
          end else begin
            next_r.dout = r.sh[15];
            next_r.sh   = {r.sh[14:0], 1'b0};
          end
          if (r.edg == {r.len, 1'b1}) begin
            next_r.st = SPIMP_TAIL;
          end else begin
            next_r.edg = r.edg + 5'h01;
          end
        end
      end
      SPIMP_TAIL: begin
        if (r.cnt != 8'h00) begin
          next_r.cnt = r.cnt - 8'h01;
        end else if (r.samp == 2'b00) begin
          next_r.cs_n    = CS_IDLE;
          next_r.rx_data = r.rx;
          next_r.done    = 1'b1;
          next_r.st      = SPIMP_IDLE;
        end
      end
      default: begin
        next_r.st   = SPIMP_IDLE;
        next_r.cs_n = CS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      r      <= '0;
      r.cs_n <= CS_IDLE;
      r.sclk <= SCLK_RST;
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    spi_o          = 4'h0;
    spi_oe         = 4'h0;
    spi_o[PIN_CS]  = r.cs_n;
    spi_oe[PIN_CS] = 1'b1;
    spi_o[PIN_CLK] = r.sclk;
    spi_oe[PIN_CLK] = 1'b1;
    spi_o[PIN_DO]  = r.dout;
    spi_oe[PIN_DO] = ~(busy & r.tw & r.rd);
    spi_oe[PIN_DI] = 1'b0;
    for (int i = 0; i < 4; i++) begin
      pin_o[i]  = gpio_mode[i] ? gpio_out[i] : spi_o[i];
      pin_oe[i] = gpio_mode[i] ? ~gpio_in_en[i] : spi_oe[i];
    end
  end

  assign busy    = (r.st != SPIMP_IDLE);
  assign done    = r.done;
  assign rx_data = r.rx_data;
  assign gpio_in = r.s2;

  // clock edge counter for checks
  logic [5:0] tog;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      tog <= 6'h00;
    end else if (r.st == SPIMP_IDLE) begin
      tog <= 6'h00;
    end else if (next_r.sclk != r.sclk) begin
      tog <= tog + 6'h01;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence seq_start;
    r.st == SPIMP_IDLE && start;
  endsequence

  sequence seq_select;
    !r.cs_n && r.st == SPIMP_LEAD;
  endsequence

  AST_START_SELECT: assert property (seq_start |=> seq_select)
    else $error("select not asserted after start");
  AST_FIRST_EDGE: assert property (
    seq_start ##1 seq_select |-> ##[1:260] $changed(r.sclk))
    else $error("no clock edge after select");
  AST_CS_HELD: assert property ($changed(r.sclk) && busy |-> !r.cs_n)
    else $error("clock edge with select high");
  AST_IDLE_CS: assert property (!busy |-> r.cs_n && pin_o[PIN_CS] | gpio_mode[PIN_CS])
    else $error("select low while idle");
  AST_EDGE_COUNT: assert property (done |-> tog == {1'b0, r.len, 1'b1} + 6'h01)
    else $error("wrong clock edge count");
  AST_CPOL_REST: assert property (done |-> r.sclk == r.cpol)
    else $error("clock not at rest level");
  AST_HALF_RANGE: assert property (
    busy |-> r.half >= 8'(HALF_MIN_CYC) && r.half <= 8'(HALF_MAX_CYC))
    else $error("half period out of range");
  AST_HALF_SPACING: assert property ($changed(r.sclk) && busy |=> $stable(r.sclk))
    else $error("clock edges too close");
  AST_4W_IN: assert property (!gpio_mode[PIN_DI] |-> !pin_oe[PIN_DI])
    else $error("data-in pad driven");
  AST_4W_OUT: assert property (
    !gpio_mode[PIN_DO] && !r.tw |-> pin_oe[PIN_DO])
    else $error("data-out pad released in 4-wire");
  AST_3W_RD: assert property (
    busy && r.tw && r.rd && !gpio_mode[PIN_DO] |-> !pin_oe[PIN_DO])
    else $error("data pad driven during 3-wire read");
  AST_GPIO_OUT: assert property (
    (pin_oe & gpio_mode & ~gpio_in_en) == (gpio_mode & ~gpio_in_en))
    else $error("general output not driven");

endmodule

// *** core/spimp_pkg.sv ***
package spimp_pkg;

  // system clock and serial bit-rate limits
  localparam int SYS_CLK_HZ   = 25_000_000;
  localparam int RATE_MIN_BPS = 102_000;
  localparam int RATE_MAX_BPS = 26_000_000;

  // half-period bounds in system cycles
  localparam int HALF_MIN_CYC = 2;
  localparam int HALF_MAX_CYC = SYS_CLK_HZ / (2 * RATE_MIN_BPS);
  localparam int HALF_FAST    = SYS_CLK_HZ / (2 * RATE_MAX_BPS);

  // word length limits
  localparam int WORD_MIN = 1;
  localparam int WORD_MAX = 16;

  // pad positions
  localparam int PIN_CS  = 0;
  localparam int PIN_CLK = 1;
  localparam int PIN_DO  = 2;
  localparam int PIN_DI  = 3;

  // reset values
  localparam logic CS_IDLE  = 1'b1;
  localparam logic SCLK_RST = 1'b0;

  typedef enum logic [1:0] {
    SPIMP_IDLE = 2'b00,
    SPIMP_LEAD = 2'b01,
    SPIMP_XFER = 2'b11,
    SPIMP_TAIL = 2'b10
  } spimp_state_t;

  typedef struct packed {
    spimp_state_t st;
    logic [7:0]   cnt;
    logic [4:0]   edg;
    logic         sclk;
    logic         cs_n;
    logic         dout;
    logic [15:0]  sh;
    logic [15:0]  rx;
    logic [15:0]  rx_data;
    logic         done;
    logic [1:0]   samp;
    logic         cpol;
    logic         cpha;
    logic         tw;
    logic         rd;
    logic [3:0]   len;
    logic [7:0]   half;
    logic [3:0]   s1;
    logic [3:0]   s2;
  } spimp_reg_t;

endpackage

// *** verification/spimp_master_tb_top.sv ***
`timescale 1ns/1ps
module spimp_master_tb_top;
  import spimp_pkg::*;
  logic        clk_sys    = 1'b0;
  logic        reset_n    = 1'b0;
  logic        start      = 1'b0;
  logic [15:0] tx_data    = 16'h0000;
  logic [3:0]  word_len   = 4'hF;
  logic        cpol       = 1'b0;
  logic        cpha       = 1'b0;
  logic        three_wire = 1'b0;
  logic        read_dir   = 1'b0;
  logic [7:0]  half_div   = 8'h04;
  logic [3:0]  gpio_mode  = 4'h0;
  logic [3:0]  gpio_in_en = 4'h0;
  logic [3:0]  gpio_out   = 4'h0;
  logic [15:0] reply      = 16'h0000;
  logic        busy;
  logic        done;
  logic        miso;
  logic [15:0] rx_data;
  logic [15:0] got;
  logic [3:0]  gpio_in;
  logic [3:0]  pin_i;
  logic [3:0]  pin_o;
  logic [3:0]  pin_oe;
  int          n_errors   = 0;
  int          n_compared = 0;
  always #20 clk_sys = ~clk_sys;
  // pads 0,1 pulled high/low when released
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & {miso, miso, 2'b01});
  spimp_master uut (.clk_sys, .reset_n, .start, .tx_data, .word_len,
    .cpol, .cpha, .three_wire, .read_dir, .half_div, .busy, .done,
    .rx_data, .gpio_mode, .gpio_in_en, .gpio_out, .gpio_in, .pin_i,
    .pin_o, .pin_oe);
  spimp_slave_model slave (.cs_n(pin_i[0]), .sclk(pin_i[1]),
    .mosi(pin_i[2]), .cpol, .cpha, .reply, .miso, .got);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic xfer(input logic [3:0] len, input logic [1:0] md,
      input logic [1:0] wr, input logic [15:0] tx, input logic [15:0] rp,
      input logic [7:0] hd, input int h);
    int n;
    int lo;
    logic [15:0] m;
    n = 0;
    lo = 2 * (len + 1) * h;
    m = 16'hFFFF >> (15 - len);
    @(posedge clk_sys);
    word_len <= len;
    {cpol, cpha} <= md;
    {three_wire, read_dir} <= wr;
    half_div <= hd;
    tx_data <= tx;
    reply <= rp << (15 - len);
    // idle clock settles at the new rest level before select falls
    @(posedge clk_sys);
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    #1;
    chk(16'(pin_o[0]), 16'h0000);
    chk(16'(busy), 16'h0001);
    chk(16'(pin_oe[3:2]), {15'h0000, wr != 2'b11});
    while (done !== 1'b1 && n < 5000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 5000) begin
      n_errors++;
      tally_and_finish();
    end
    if (wr != 2'b10) chk(rx_data, rp & m);
    if (wr != 2'b11) chk(got, tx & m);
    chk(16'(pin_o[0]), 16'h0001);
    chk(16'(pin_o[1]), 16'(md[1]));
    chk(16'(n >= lo && n <= lo + 2 * h + 6), 16'h0001);
  endtask
  initial begin
    repeat (19) @(posedge clk_sys);
    #1;
    chk({pin_o[0], busy, rx_data[13:0]}, 16'h8000);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      xfer(4'hF, 2'(i), 2'b00, 16'hA5C3, 16'h3C5A, 8'h04, 4);
    end
    // reset in the middle of a word
    @(posedge clk_sys);
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(16'(pin_o[0]), 16'h0001);
    chk(16'(busy), 16'h0000);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    xfer(4'h0, 2'b00, 2'b00, 16'h0001, 16'h0001, 8'h00, 2);
    xfer(4'h7, 2'b01, 2'b10, 16'h00B6, 16'h0000, 8'hFF, 122);
    xfer(4'hB, 2'b10, 2'b11, 16'h0000, 16'h0A5D, 8'h03, 3);
    @(posedge clk_sys);
    gpio_mode <= 4'hF;
    gpio_out <= 4'hA;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(16'(pin_o), 16'h000A);
    chk(16'(pin_oe), 16'h000F);
    @(posedge clk_sys);
    gpio_in_en <= 4'h3;
    repeat (4) @(posedge clk_sys);
    #1;
    chk(16'(gpio_in), 16'h0009);
    chk(16'(pin_oe), 16'h000C);
    tally_and_finish();
  end
endmodule

// *** verification/spimp_slave_model.sv ***
`timescale 1ns/1ps
module spimp_slave_model (
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        mosi,
  input  wire logic        cpol,
  input  wire logic        cpha,
  input  wire logic [15:0] reply,
  output logic             miso,
  output logic [15:0]      got
);
  logic [15:0] sh;
  logic        first;
  initial miso = 1'b1;
  always @(negedge cs_n) begin
    sh = reply;
    miso = reply[15];
    got = 16'h0000;
    first = cpha;
  end
  // deselected: no stale data
  always @(posedge cs_n) miso = ~miso;
  always @(sclk) begin
    if (!cs_n && ((sclk != cpol) != cpha)) begin
      got = {got[14:0], mosi};
    end else if (!cs_n && first) begin
      first = 1'b0;
    end else if (!cs_n) begin
      sh = sh << 1;
      miso = sh[15];
    end
  end
endmodule
